// File: inc/rfwk_pkg.sv
// Constants, register map and helpers for the receiver wake control block
package rfwk_pkg;
  localparam int CLK_MHZ = 40;
  localparam int PRESCALE_DIV = 256;
  localparam logic [7:0] PRESCALE_LAST = 8'hFF;
  localparam logic [7:0] WAKE_TERM = 8'h80;
  localparam int BOOST_TIME_US = 10000;
  localparam int BOOST_CYC = BOOST_TIME_US * CLK_MHZ;
  localparam int BOOST_W = 20;
  localparam logic [15:0] BW_BASE_HZ = 16'h0271;
  localparam logic [7:0] OFS_CTRL = 8'h00;
  localparam logic [7:0] OFS_STATUS = 8'h04;
  localparam logic [7:0] OFS_BW = 8'h08;
  localparam logic [7:0] OFS_IRQ_STAT = 8'h0C;
  localparam logic [7:0] OFS_IRQ_EN = 8'h10;
  localparam logic [7:0] OFS_IRQ_CLR = 8'h14;
  localparam int CTRL_SEL_LOW = 0;
  localparam int CTRL_SEL_HIGH = 1;
  localparam int CTRL_SWEEP = 2;
  localparam int CTRL_SHUT = 3;
  localparam logic [3:0] CTRL_RST = 4'hF;
  localparam int ST_WAKE = 0;
  localparam int ST_FIXED = 3;
  localparam int ST_BOOST = 4;
  localparam int ST_RXEN = 5;
  localparam int ST_CNT_LSB = 8;
  localparam int IRQ_N = 3;
  localparam int IRQ_WAKE_ON = 0;
  localparam int IRQ_WAKE_OFF = 1;
  localparam int IRQ_BOOST_END = 2;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  typedef enum logic [0:0] {
    RFWK_SWEEP_type_dummy = 1'b0
  } rfwk_unused_type;

  // Binary-weighted filter steps; fixed mode sits one step above sweep
  function automatic logic [15:0] bw_hz(input logic sel_low, input logic sel_high,
                                        input logic sweep);
    logic [2:0] shift;
    shift = {1'b0, sel_high, sel_low} + {2'h0, ~sweep};
    bw_hz = BW_BASE_HZ << shift;
  endfunction
endpackage

// File: hw/rfwk_prescaler.sv
// Divide-by-256 tick generator for the wake qualification clock
`timescale 1ns/1ps
`default_nettype none
module rfwk_prescaler (
  input wire logic sys_clk_i,
  input wire logic rstn_i,
  input wire logic clr_i,
  output logic tick_o
);
  logic [7:0] div_r;
  logic [7:0] div_nxt;

  assign div_nxt = clr_i ? 8'h00 : div_r + 8'h01;
  assign tick_o = !clr_i && (div_r == rfwk_pkg::PRESCALE_LAST);

  always_ff @(posedge sys_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      div_r <= 8'h00;
    end else begin
      div_r <= div_nxt;
    end
  end
endmodule // rfwk_prescaler
`default_nettype wire

// File: hw/rfwk_wake_qual.sv
// Carrier qualification counter driving the wake flag
`timescale 1ns/1ps
`default_nettype none
module rfwk_wake_qual (
  input wire logic sys_clk_i,
  input wire logic rstn_i,
  input wire logic clr_i,
  input wire logic tick_i,
  input wire logic carrier_i,
  output logic [7:0] count_o,
  output logic wake_o
);
  logic [7:0] cnt_r;
  logic [7:0] cnt_nxt;
  logic wake_r;
  wire logic at_term = (cnt_r == rfwk_pkg::WAKE_TERM);

  // Carrier loss clears at once; a full count holds rather than wrapping
  assign cnt_nxt = (clr_i || !carrier_i) ? 8'h00 :
                   (tick_i && !at_term) ? cnt_r + 8'h01 : cnt_r;

  always_ff @(posedge sys_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      cnt_r <= 8'h00;
      wake_r <= 1'b0;
    end else begin
      cnt_r <= cnt_nxt;
      wake_r <= (cnt_nxt == rfwk_pkg::WAKE_TERM);
    end
  end

  assign count_o = cnt_r;
  assign wake_o = wake_r;
endmodule // rfwk_wake_qual
`default_nettype wire

// File: hw/rfwk_top.sv
// Receiver wake control: bandwidth select, shutdown, wake flag, AGC boost, AXI4-Lite
// Notes on behaviour
// - Select pair picks one of four bandwidths
// - Select map binary weighted; fixed doubles sweep
// - Shutdown high stops reception, low power
// - Shutdown defaults high when not driven
// - Wake output goes low on constant carrier
// - No wake detection or assertion in shutdown
// - Wake only after 128 system ticks of carrier
// - System tick is reference clock over 256
// - Carrier loss clears counter; restart from zero
// - Wake stays low while carrier remains
// - Data output ungated, toggles with noise
// - Control inputs read high when unconnected
// - Boost AGC currents about 10 ms after release
`timescale 1ns/1ps
`default_nettype none
module rfwk_top #(
  parameter int BOOST_CYCLES = rfwk_pkg::BOOST_CYC
) (
  input wire logic sys_clk_i,
  input wire logic rstn_i,
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic carrier_det_i,
  input wire logic demod_data_i,
  output logic data_o,
  output logic carrier_wake_n_o,
  output logic rx_enable_o,
  output logic agc_boost_o,
  output logic [15:0] bw_hz_o,
  output logic irq_o
);
  localparam int BOOST_W_L = rfwk_pkg::BOOST_W;
  localparam logic [BOOST_W_L-1:0] BOOST_LOAD = BOOST_W_L'(BOOST_CYCLES);
  logic [3:0] ctrl_r;
  logic aw_got_r;
  logic w_got_r;
  logic [7:0] awaddr_r;
  logic [31:0] wdata_r;
  logic wstrb0_r;
  logic bvalid_r;
  logic [1:0] bresp_r;
  logic rvalid_r;
  logic [31:0] rdata_r;
  logic [1:0] rresp_r;
  logic [BOOST_W_L-1:0] boost_r;
  logic shut_q_r;
  logic wake_q_r;
  logic [rfwk_pkg::IRQ_N-1:0] irq_stat_r;
  logic [rfwk_pkg::IRQ_N-1:0] irq_en_r;
  logic data_r;
  logic [15:0] bw_r;

  wire logic shut = ctrl_r[rfwk_pkg::CTRL_SHUT];
  wire logic tick;
  wire logic wake;
  wire logic [7:0] qual_cnt;

  // Prescaler and counter are held clear throughout shutdown
  rfwk_prescaler u_pre (
    .sys_clk_i(sys_clk_i),
    .rstn_i(rstn_i),
    .clr_i(shut),
    .tick_o(tick)
  );

  rfwk_wake_qual u_qual (
    .sys_clk_i(sys_clk_i),
    .rstn_i(rstn_i),
    .clr_i(shut),
    .tick_i(tick),
    .carrier_i(carrier_det_i),
    .count_o(qual_cnt),
    .wake_o(wake)
  );

  // Write path: address and data may arrive in either order
  wire logic aw_take = s_axi_awvalid && s_axi_awready;
  wire logic w_take = s_axi_wvalid && s_axi_wready;
  wire logic aw_have = aw_got_r || aw_take;
  wire logic w_have = w_got_r || w_take;
  wire logic do_wr = aw_have && w_have && !bvalid_r;
  wire logic [7:0] wr_addr = aw_got_r ? awaddr_r : s_axi_awaddr;
  wire logic [31:0] wr_data = w_got_r ? wdata_r : s_axi_wdata;
  wire logic wr_lane0 = w_got_r ? wstrb0_r : s_axi_wstrb[0];
  wire logic wr_ctrl = do_wr && wr_lane0 && (wr_addr == rfwk_pkg::OFS_CTRL);
  wire logic wr_en = do_wr && wr_lane0 && (wr_addr == rfwk_pkg::OFS_IRQ_EN);
  wire logic wr_clr = do_wr && wr_lane0 && (wr_addr == rfwk_pkg::OFS_IRQ_CLR);
  wire logic wr_ok = (wr_addr == rfwk_pkg::OFS_CTRL) || (wr_addr == rfwk_pkg::OFS_IRQ_EN) ||
                     (wr_addr == rfwk_pkg::OFS_IRQ_CLR);

  assign s_axi_awready = !aw_got_r && !bvalid_r;
  assign s_axi_wready = !w_got_r && !bvalid_r;
  assign s_axi_bvalid = bvalid_r;
  assign s_axi_bresp = bresp_r;

  always_ff @(posedge sys_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      aw_got_r <= 1'b0;
      w_got_r <= 1'b0;
      awaddr_r <= 8'h00;
      wdata_r <= 32'h0000_0000;
      wstrb0_r <= 1'b0;
      bvalid_r <= 1'b0;
      bresp_r <= rfwk_pkg::RESP_OKAY;
    end else begin
      if (aw_take) begin
        awaddr_r <= s_axi_awaddr;
      end
      if (w_take) begin
        wdata_r <= s_axi_wdata;
        wstrb0_r <= s_axi_wstrb[0];
      end
      aw_got_r <= aw_have && !do_wr;
      w_got_r <= w_have && !do_wr;
      if (do_wr) begin
        bvalid_r <= 1'b1;
        bresp_r <= wr_ok ? rfwk_pkg::RESP_OKAY : rfwk_pkg::RESP_SLVERR;
      end else if (s_axi_bready) begin
        bvalid_r <= 1'b0;
      end
    end
  end

  // Control bits reset high, as a floating pin would read
  always_ff @(posedge sys_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      ctrl_r <= rfwk_pkg::CTRL_RST;
    end else if (wr_ctrl) begin
      ctrl_r <= wr_data[3:0];
    end
  end

  // Bandwidth decode, registered for a glitch-free filter setting
  wire logic [15:0] bw_sel = rfwk_pkg::bw_hz(ctrl_r[rfwk_pkg::CTRL_SEL_LOW],
    ctrl_r[rfwk_pkg::CTRL_SEL_HIGH], ctrl_r[rfwk_pkg::CTRL_SWEEP]);

  // Boost restarts on every release so each poll window recovers the AGC
  wire logic shut_rel = shut_q_r && !shut;
  wire logic [BOOST_W_L-1:0] boost_nxt = shut ? '0 : shut_rel ? BOOST_LOAD :
    (boost_r != '0) ? boost_r - BOOST_W_L'(1) : boost_r;
  wire logic boost_end = (boost_r == BOOST_W_L'(1)) && !shut_rel && !shut;

  wire logic [rfwk_pkg::IRQ_N-1:0] irq_ev = {boost_end, wake_q_r && !wake, !wake_q_r && wake};
  wire logic [rfwk_pkg::IRQ_N-1:0] irq_stat_nxt =
    irq_ev | (irq_stat_r & ~(wr_clr ? wr_data[rfwk_pkg::IRQ_N-1:0] : '0));

  always_ff @(posedge sys_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      bw_r <= 16'h0000;
      boost_r <= '0;
      shut_q_r <= 1'b1;
      wake_q_r <= 1'b0;
      irq_stat_r <= '0;
      irq_en_r <= '0;
      data_r <= 1'b0;
    end else begin
      bw_r <= bw_sel;
      boost_r <= boost_nxt;
      shut_q_r <= shut;
      wake_q_r <= wake;
      irq_stat_r <= irq_stat_nxt;
      if (wr_en) begin
        irq_en_r <= wr_data[rfwk_pkg::IRQ_N-1:0];
      end
      data_r <= demod_data_i;
    end
  end

  assign bw_hz_o = bw_r;
  assign agc_boost_o = (boost_r != '0);
  assign rx_enable_o = !shut;
  assign carrier_wake_n_o = !wake;
  assign data_o = data_r;
  assign irq_o = |(irq_stat_r & irq_en_r);

  // Read path
  wire logic [31:0] status_word = {16'h0000, qual_cnt, 2'h0, !shut, agc_boost_o,
    !ctrl_r[rfwk_pkg::CTRL_SWEEP], ctrl_r[rfwk_pkg::CTRL_SEL_HIGH],
    ctrl_r[rfwk_pkg::CTRL_SEL_LOW], wake};
  wire logic rd_ctrl = (s_axi_araddr == rfwk_pkg::OFS_CTRL);
  wire logic rd_stat = (s_axi_araddr == rfwk_pkg::OFS_STATUS);
  wire logic rd_bw = (s_axi_araddr == rfwk_pkg::OFS_BW);
  wire logic rd_ist = (s_axi_araddr == rfwk_pkg::OFS_IRQ_STAT);
  wire logic rd_ien = (s_axi_araddr == rfwk_pkg::OFS_IRQ_EN);
  wire logic rd_ok = rd_ctrl || rd_stat || rd_bw || rd_ist || rd_ien;
  wire logic [31:0] rd_word = rd_ctrl ? {28'h0000000, ctrl_r} :
                              rd_stat ? status_word :
                              rd_bw ? {16'h0000, bw_r} :
                              rd_ist ? {29'h0, irq_stat_r} :
                              rd_ien ? {29'h0, irq_en_r} : 32'h0000_0000;

  assign s_axi_arready = !rvalid_r;
  assign s_axi_rvalid = rvalid_r;
  assign s_axi_rdata = rdata_r;
  assign s_axi_rresp = rresp_r;

  always_ff @(posedge sys_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      rvalid_r <= 1'b0;
      rdata_r <= 32'h0000_0000;
      rresp_r <= rfwk_pkg::RESP_OKAY;
    end else if (s_axi_arvalid && !rvalid_r) begin
      rvalid_r <= 1'b1;
      rdata_r <= rd_word;
      rresp_r <= rd_ok ? rfwk_pkg::RESP_OKAY : rfwk_pkg::RESP_SLVERR;
    end else if (s_axi_rready) begin
      rvalid_r <= 1'b0;
    end
  end

  // Checks
  sequence carrier_held_s;
    carrier_det_i && !shut;
  endsequence

  sequence qualified_s;
    qual_cnt == rfwk_pkg::WAKE_TERM;
  endsequence

  bw_map_a: assert property (@(posedge sys_clk_i) disable iff (!rstn_i)
    wr_ctrl && (wr_data[2:0] == 3'h3) |=> ##1 (bw_hz_o == 16'h2710))
    else $error("fixed mode widest bandwidth wrong");

  bw_sweep_a: assert property (@(posedge sys_clk_i) disable iff (!rstn_i)
    wr_ctrl && (wr_data[2:0] == 3'h4) |=> ##1 (bw_hz_o == 16'h0271))
    else $error("sweep narrowest bandwidth wrong");

  shut_rx_a: assert property (@(posedge sys_clk_i) disable iff (!rstn_i)
    shut |-> !rx_enable_o)
    else $error("receiver enabled in shutdown");

  shut_dflt_a: assert property (@(posedge sys_clk_i) disable iff (!rstn_i)
    $rose(rstn_i) |-> shut && ctrl_r == rfwk_pkg::CTRL_RST)
    else $error("shutdown not default after reset");

  wake_shut_a: assert property (@(posedge sys_clk_i) disable iff (!rstn_i)
    shut |=> carrier_wake_n_o && qual_cnt == 8'h00)
    else $error("wake active in shutdown");

  wake_qual_a: assert property (@(posedge sys_clk_i) disable iff (!rstn_i)
    $fell(carrier_wake_n_o) |-> qualified_s and $past(tick))
    else $error("wake asserted before full count");

  tick_rate_a: assert property (@(posedge sys_clk_i) disable iff (!rstn_i)
    tick |=> (!tick)[*8])
    else $error("prescaler tick too frequent");

  wake_lose_a: assert property (@(posedge sys_clk_i) disable iff (!rstn_i)
    !carrier_det_i |=> qual_cnt == 8'h00 && carrier_wake_n_o)
    else $error("counter not cleared on carrier loss");

  wake_hold_a: assert property (@(posedge sys_clk_i) disable iff (!rstn_i)
    qualified_s ##0 carrier_held_s |=> (!carrier_wake_n_o) and qualified_s)
    else $error("wake dropped while carrier present");

  boost_on_a: assert property (@(posedge sys_clk_i) disable iff (!rstn_i)
    $fell(shut) |=> agc_boost_o [*8])
    else $error("boost not held after release");

  data_pass_a: assert property (@(posedge sys_clk_i) disable iff (!rstn_i)
    $past(rstn_i) |-> data_o == $past(demod_data_i))
    else $error("data output gated");

  irq_set_a: assert property (@(posedge sys_clk_i) disable iff (!rstn_i)
    irq_ev[rfwk_pkg::IRQ_WAKE_ON] |=> irq_stat_r[rfwk_pkg::IRQ_WAKE_ON])
    else $error("wake event lost against clear");

  cnt_step_a: assert property (@(posedge sys_clk_i) disable iff (!rstn_i)
    tick && carrier_det_i && !shut && (qual_cnt != rfwk_pkg::WAKE_TERM) |=>
    qual_cnt == $past(qual_cnt) + 8'h01)
    else $error("qualification count missed a tick");

  cnt_sat_a: assert property (@(posedge sys_clk_i) disable iff (!rstn_i)
    qual_cnt <= rfwk_pkg::WAKE_TERM)
    else $error("qualification count ran past its limit");

  boost_stop_a: assert property (@(posedge sys_clk_i) disable iff (!rstn_i)
    shut |=> !agc_boost_o)
    else $error("boost running in shutdown");

  irq_clr_a: assert property (@(posedge sys_clk_i) disable iff (!rstn_i)
    wr_clr && wr_data[rfwk_pkg::IRQ_BOOST_END] && !irq_ev[rfwk_pkg::IRQ_BOOST_END] |=>
    !irq_stat_r[rfwk_pkg::IRQ_BOOST_END])
    else $error("status bit not cleared by write");
endmodule // rfwk_top
`default_nettype wire

// File: dv/rfwk_rf_model.sv
// Front end stand-in: carrier detect level and slicer data with idle noise
`timescale 1ns/1ps
`default_nettype none
module rfwk_rf_model (
  input wire logic sys_clk_i,
  input wire logic carrier_on_i,
  output logic carrier_det_o,
  output logic demod_data_o
);
  integer seed;
  initial begin
    seed = 32'h9362EA9A;
    carrier_det_o = 1'b0;
    demod_data_o = 1'b0;
  end
  always @(posedge sys_clk_i) begin
    carrier_det_o <= carrier_on_i;
    // Without a carrier the slicer wanders, so a stuck value never passes for data
    demod_data_o <= carrier_on_i ? 1'b1 : 1'($random(seed));
  end
endmodule // rfwk_rf_model
`default_nettype wire

// File: dv/rfwk_top_tb.sv
// Self-checking bench for the receiver wake control block
`timescale 1ns/1ps
`default_nettype none
module rfwk_top_tb;
  logic sys_clk_i = 1'b0;
  logic rstn_i = 1'b0;
  logic [7:0] s_axi_awaddr = 8'h00;
  logic [7:0] s_axi_araddr = 8'h00;
  logic [31:0] s_axi_wdata = 32'h0;
  logic [3:0] s_axi_wstrb = 4'hF;
  logic s_axi_awvalid = 1'b0;
  logic s_axi_wvalid = 1'b0;
  logic s_axi_bready = 1'b0;
  logic s_axi_arvalid = 1'b0;
  logic s_axi_rready = 1'b0;
  logic carrier_on = 1'b0;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  logic [31:0] s_axi_rdata;
  logic carrier_det_i, demod_data_i, data_o, carrier_wake_n_o, rx_enable_o, agc_boost_o, irq_o;
  logic d_prev;
  logic [15:0] bw_hz_o;
  logic [2:0] sh;
  logic [33:0] exp_q[$];
  int fail_count = 0;
  int n_tests = 0;
  int cyc = 0;
  int rel = 0;

  rfwk_top #(.BOOST_CYCLES(20)) u_rfwk_top (
    .sys_clk_i, .rstn_i, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
    .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
    .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
    .s_axi_rready, .carrier_det_i, .demod_data_i, .data_o, .carrier_wake_n_o, .rx_enable_o,
    .agc_boost_o, .bw_hz_o, .irq_o
  );
  rfwk_rf_model u_rfwk_rf_model (
    .sys_clk_i, .carrier_on_i(carrier_on), .carrier_det_o(carrier_det_i),
    .demod_data_o(demod_data_i)
  );

  initial forever #12.5 sys_clk_i = ~sys_clk_i;

  // Response watcher: each answer taken on the bus is matched with the oldest note
  always @(posedge sys_clk_i) begin
    cyc <= cyc + 1;
    d_prev <= demod_data_i;
    if (s_axi_rvalid === 1'b1 && s_axi_rready === 1'b1)
      check({s_axi_rresp, s_axi_rdata}, exp_q.pop_front());
    if (s_axi_bvalid === 1'b1 && s_axi_bready === 1'b1)
      check({s_axi_bresp, 32'h0}, exp_q.pop_front());
  end

  task automatic check(input logic [33:0] got, input logic [33:0] exp);
    n_tests++;
    if (got !== exp) begin
      fail_count++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    check({18'h0, got}, {18'h0, exp});
  endtask

  task automatic give_verdict;
    $display("Counts: %0d comparisons, %0d mismatches", n_tests, fail_count);
    if (fail_count == 0 && n_tests > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask

  task automatic bail;
    fail_count++;
    give_verdict;
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] r = 2'h0);
    int n;
    exp_q.push_back({r, 32'h0});
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    n = 0;
    do begin
      @(posedge sys_clk_i);
      n++;
      if (s_axi_awready === 1'b1) s_axi_awvalid <= 1'b0;
      if (s_axi_wready === 1'b1) s_axi_wvalid <= 1'b0;
    end while (s_axi_bvalid !== 1'b1 && n < 100);
    // Ready stays high between calls, so a back-to-back call never sets it twice in one step
    if (n >= 100) bail;
  endtask

  task automatic rd(input logic [7:0] a, input logic [31:0] d, input logic [1:0] r = 2'h0);
    int n;
    exp_q.push_back({r, d});
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    n = 0;
    do begin
      @(posedge sys_clk_i);
      n++;
      if (s_axi_arready === 1'b1) s_axi_arvalid <= 1'b0;
    end while (s_axi_rvalid !== 1'b1 && n < 100);
    if (n >= 100) bail;
  endtask

  // Qualification is timed from the release write; margins allow for bus latency
  task automatic qualify;
    int n;
    while (cyc - rel < 32760) @(posedge sys_clk_i);
    @(negedge sys_clk_i);
    chk(carrier_wake_n_o, 16'h1);
    n = 0;
    while (carrier_wake_n_o !== 1'b0 && n < 40) begin
      @(posedge sys_clk_i);
      n++;
    end
    @(negedge sys_clk_i);
    chk(carrier_wake_n_o, 16'h0);
    @(posedge sys_clk_i);
  endtask

  initial begin
    repeat (20) @(posedge sys_clk_i);
    rstn_i <= 1'b1;
    @(posedge sys_clk_i);
    @(negedge sys_clk_i);
    chk(rx_enable_o, 16'h0);
    chk(carrier_wake_n_o, 16'h1);
    @(posedge sys_clk_i);
    rd(rfwk_pkg::OFS_CTRL, 32'hF);
    rd(rfwk_pkg::OFS_STATUS, 32'h6);
    rd(rfwk_pkg::OFS_IRQ_EN, 32'h0);
    rd(8'h18, 32'h0, rfwk_pkg::RESP_SLVERR);
    wr(8'h18, 32'h1, rfwk_pkg::RESP_SLVERR);
    $display("reset and map test done");
    for (int i = 0; i < 8; i++) begin
      sh = 3'(i[1:0]) + 3'(!i[2]);
      wr(rfwk_pkg::OFS_CTRL, 32'h8 | 32'(i));
      rd(rfwk_pkg::OFS_BW, 32'(16'h0271 << sh));
      rd(rfwk_pkg::OFS_STATUS, 32'({!i[2], i[1], i[0], 1'b0}));
      @(negedge sys_clk_i);
      chk(bw_hz_o, 16'h0271 << sh);
      @(posedge sys_clk_i);
    end
    $display("bandwidth test done");
    repeat (64) begin
      @(negedge sys_clk_i);
      chk(data_o, d_prev);
    end
    carrier_on <= 1'b1;
    repeat (300) begin
      @(negedge sys_clk_i);
      chk(carrier_wake_n_o, 16'h1);
    end
    @(posedge sys_clk_i);
    rd(rfwk_pkg::OFS_STATUS, 32'h6);
    // Host pulls shutdown low; widest sweep step suits the short pulses it expects
    wr(rfwk_pkg::OFS_CTRL, 32'h7);
    rel = cyc;
    @(negedge sys_clk_i);
    chk(rx_enable_o, 16'h1);
    chk(agc_boost_o, 16'h1);
    repeat (30) @(posedge sys_clk_i);
    @(negedge sys_clk_i);
    chk(agc_boost_o, 16'h0);
    chk(irq_o, 16'h0);
    @(posedge sys_clk_i);
    rd(rfwk_pkg::OFS_IRQ_STAT, 32'h4);
    wr(rfwk_pkg::OFS_IRQ_EN, 32'h7);
    @(negedge sys_clk_i);
    chk(irq_o, 16'h1);
    @(posedge sys_clk_i);
    wr(rfwk_pkg::OFS_IRQ_CLR, 32'h4);
    rd(rfwk_pkg::OFS_IRQ_STAT, 32'h0);
    @(negedge sys_clk_i);
    chk(irq_o, 16'h0);
    qualify;
    $display("first qualification test done");
    repeat (1000) begin
      @(negedge sys_clk_i);
      chk(carrier_wake_n_o, 16'h0);
    end
    @(posedge sys_clk_i);
    rd(rfwk_pkg::OFS_STATUS, 32'h8027);
    rd(rfwk_pkg::OFS_IRQ_STAT, 32'h1);
    @(negedge sys_clk_i);
    chk(irq_o, 16'h1);
    carrier_on <= 1'b0;
    repeat (3) @(posedge sys_clk_i);
    @(negedge sys_clk_i);
    chk(carrier_wake_n_o, 16'h1);
    @(posedge sys_clk_i);
    rd(rfwk_pkg::OFS_STATUS, 32'h26);
    rd(rfwk_pkg::OFS_IRQ_STAT, 32'h3);
    wr(rfwk_pkg::OFS_IRQ_CLR, 32'h7);
    carrier_on <= 1'b1;
    repeat (1000) @(posedge sys_clk_i);
    wr(rfwk_pkg::OFS_CTRL, 32'hF);
    rd(rfwk_pkg::OFS_STATUS, 32'h6);
    wr(rfwk_pkg::OFS_CTRL, 32'h7);
    rel = cyc;
    qualify;
    $display("shutdown restart test done");
    give_verdict;
  end
endmodule // rfwk_top_tb
`default_nettype wire
